// file: rtl/fmad_pkg.sv
// Purpose: shared constants and types of the flash map access decoder
// Assumes: byte addresses on a 32-bit code space
// Notes:   page geometry and map bases are fixed by the flash layout
package fmad_pkg;

  // page geometry
  localparam int unsigned PAGE_SHIFT     = 10;
  localparam logic [31:0] PAGE_BYTES     = 32'h0000_0400;
  localparam int unsigned MAIN_PAGES_MAX = 32;

  // main block map
  localparam logic [31:0] MAIN_BASE      = 32'h0000_0000;
  localparam logic [31:0] MAIN_LAST_PAGE = 32'h0000_7c00;
  localparam logic [31:0] MAIN_RSVD_BASE = 32'h0000_8000;

  // information block map
  localparam logic [31:0] INFO_BASE      = 32'h0fe0_0000;
  localparam logic [31:0] UD_RSVD_BASE   = 32'h0fe0_0400;
  localparam logic [31:0] LB_BASE        = 32'h0fe0_4000;
  localparam logic [31:0] DI_BASE        = 32'h0fe0_8000;
  localparam logic [31:0] INFO_RSVD_BASE = 32'h0fe1_0000;

  // request kinds
  localparam logic [1:0] KIND_READ  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_ERASE = 2'h2;

  // energy modes
  localparam logic [2:0] MODE_RUN         = 3'h0;
  localparam logic [2:0] MODE_LIGHT_SLEEP = 3'h1;

  // read wait-state threshold and core clock
  localparam int unsigned CORE_CLK_HZ  = 20_000_000;
  localparam int unsigned WS0_MAX_HZ   = 16_000_000;

  // flash pulse lengths in internal oscillator ticks
  localparam logic [15:0] WRITE_TICKS  = 16'h0014;
  localparam logic [15:0] ERASE_TICKS  = 16'h0100;

  // reset values
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // decoded flash regions
  typedef enum logic [2:0] {
    REG_MAIN,
    REG_UD,
    REG_LB,
    REG_DI,
    REG_RSVD
  } fmad_region_t;

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_ERASE,
    ST_DEV_ERASE
  } fmad_state_t;

endpackage

// file: rtl/fmad_flash_map_access_decoder.sv
// Purpose: flash map decode, access permissions and flash operation timing
// Assumes: one outstanding bus request; osc_tick_in is a synchronous pulse
//          from the internal flash oscillator
// Notes:   no software registers; control levels are plain ports
`timescale 1ns/100ps

// Operation
// - main block up to 32 pages, size parameter
// - all pages 1024 bytes, low ten bits
// - main at zero, reserved from 0x8000
// - user data page at info base, writable
// - user data 1 kB, gap reserved
// - lock page writable, erase by debug only
// - device info page read-only
// - above info block reserved, no content
// - access only in run or light sleep
// - cpu program in run, dma writes also sleep
// - zero wait states up to 16 MHz
// - pulses timed by internal oscillator ticks
// - optional erase abort on interrupt
// - separate write and erase completion events
// - debug device erase clears all main pages
// - device erase leaves user data page alone
// - lock bit zero blocks main page changes
module fmad_flash_map_access_decoder #(
  parameter int unsigned MAIN_PAGES  = fmad_pkg::MAIN_PAGES_MAX,
  parameter int unsigned CORE_HZ     = fmad_pkg::CORE_CLK_HZ,
  parameter logic [15:0] WRITE_TICKS = fmad_pkg::WRITE_TICKS,
  parameter logic [15:0] ERASE_TICKS = fmad_pkg::ERASE_TICKS
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // bus request
  input  wire logic        req_valid_in,
  input  wire logic [1:0]  req_kind_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  input  wire logic        req_dma_in,
  input  wire logic        req_debug_in,
  output logic             req_ready_out,
  // bus answer
  output logic             resp_valid_out,
  output logic             resp_err_out,
  output logic [31:0]      resp_rdata_out,
  // system state and options
  input  wire logic [2:0]  energy_mode_in,
  input  wire logic [31:0] page_lock_word_in,
  input  wire logic        erase_abort_en_in,
  input  wire logic        irq_pending_in,
  input  wire logic        osc_tick_in,
  input  wire logic        debug_erase_start_in,
  output logic             debug_erase_busy_out,
  // flash array
  output logic             flash_rd_out,
  output logic             flash_prog_out,
  output logic             flash_erase_out,
  output logic [31:0]      flash_addr_out,
  output logic [31:0]      flash_wdata_out,
  input  wire logic [31:0] flash_rdata_in,
  // completion events
  output logic             write_done_out,
  output logic             erase_done_out
);

  // main block span from the fitted page count
  localparam logic [31:0] MAIN_BYTES =
    32'(MAIN_PAGES) << fmad_pkg::PAGE_SHIFT;
  localparam logic        WAIT_STATE = (CORE_HZ > fmad_pkg::WS0_MAX_HZ);
  localparam logic [4:0]  LAST_PAGE  = 5'(MAIN_PAGES - 1);

  // reset synchroniser
  logic rst_meta_ff;
  logic rst_n_ff;

  // state
  fmad_pkg::fmad_state_t state_ff;
  fmad_pkg::fmad_state_t nxt_state;
  logic [15:0] tick_cnt_ff;
  logic        wait_ff;
  logic [4:0]  dev_page_ff;
  logic        dev_lb_ff;
  logic        resp_valid_ff;
  logic        resp_err_ff;
  logic [31:0] rdata_ff;
  logic        flash_rd_ff;
  logic        flash_prog_ff;
  logic        flash_erase_ff;
  logic [31:0] flash_addr_ff;
  logic [31:0] flash_wdata_ff;
  logic        write_done_ff;
  logic        erase_done_ff;

  // decode of the incoming request
  fmad_pkg::fmad_region_t req_region;
  logic        take_req;
  logic        start_dev;
  logic        refuse;
  logic        pulse_over;
  logic        abort_erase;

  // map an address onto a flash region
  function automatic fmad_pkg::fmad_region_t region_of(input logic [31:0] a);
    fmad_pkg::fmad_region_t r;
    r = fmad_pkg::REG_RSVD;
    if (a < MAIN_BYTES) begin
      r = fmad_pkg::REG_MAIN;
    end else if (a >= fmad_pkg::INFO_BASE && a < fmad_pkg::UD_RSVD_BASE) begin
      r = fmad_pkg::REG_UD;
    end else if (a >= fmad_pkg::LB_BASE && a < fmad_pkg::LB_BASE + fmad_pkg::PAGE_BYTES) begin
      r = fmad_pkg::REG_LB;
    end else if (a >= fmad_pkg::DI_BASE && a < fmad_pkg::DI_BASE + fmad_pkg::PAGE_BYTES) begin
      r = fmad_pkg::REG_DI;
    end
    return r;
  endfunction

  // lock bit of the main page that holds an address
  function automatic logic page_unlocked(input logic [31:0] a, input logic [31:0] page_lock_word);
    return page_lock_word[a[fmad_pkg::PAGE_SHIFT +: 5]];
  endfunction

  // release reset through two flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // device erase wins over a bus request in the same cycle
  assign start_dev     = (state_ff == fmad_pkg::ST_IDLE) && debug_erase_start_in;
  assign req_ready_out = (state_ff == fmad_pkg::ST_IDLE) && !debug_erase_start_in;
  assign take_req      = req_ready_out && req_valid_in;
  assign req_region    = region_of(req_addr_in);

  // permission check, evaluated at the accepting edge
  always_comb begin
    refuse = 1'b0;
    if (req_region == fmad_pkg::REG_RSVD) begin
      refuse = 1'b1;
    end
    if (energy_mode_in != fmad_pkg::MODE_RUN &&
        energy_mode_in != fmad_pkg::MODE_LIGHT_SLEEP) begin
      refuse = 1'b1;
    end
    if (req_kind_in != fmad_pkg::KIND_READ) begin
      // cpu programs only in run; dma may only write, in run or light sleep
      if (!req_debug_in && !req_dma_in && energy_mode_in != fmad_pkg::MODE_RUN) begin
        refuse = 1'b1;
      end
      if (req_dma_in && req_kind_in != fmad_pkg::KIND_WRITE) begin
        refuse = 1'b1;
      end
      if (req_region == fmad_pkg::REG_DI) begin
        refuse = 1'b1;
      end
      if (req_region == fmad_pkg::REG_LB && req_kind_in == fmad_pkg::KIND_ERASE &&
          !req_debug_in) begin
        refuse = 1'b1;
      end
      if (req_region == fmad_pkg::REG_MAIN && !page_unlocked(req_addr_in, page_lock_word_in)) begin
        refuse = 1'b1;
      end
    end
    if (req_kind_in != fmad_pkg::KIND_READ && req_kind_in != fmad_pkg::KIND_WRITE &&
        req_kind_in != fmad_pkg::KIND_ERASE) begin
      refuse = 1'b1;
    end
  end

  // pulse ends on the tick that brings the count to its target
  assign pulse_over  = osc_tick_in && (tick_cnt_ff == 16'h0001);
  // only a plain page erase may be cut short, never the device erase
  assign abort_erase = erase_abort_en_in && irq_pending_in;

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fmad_pkg::ST_IDLE: begin
        if (start_dev) begin
          nxt_state = fmad_pkg::ST_DEV_ERASE;
        end else if (take_req && !refuse) begin
          if (req_kind_in == fmad_pkg::KIND_READ) begin
            nxt_state = fmad_pkg::ST_READ;
          end else if (req_kind_in == fmad_pkg::KIND_WRITE) begin
            nxt_state = fmad_pkg::ST_WRITE;
          end else begin
            nxt_state = fmad_pkg::ST_ERASE;
          end
        end
      end
      fmad_pkg::ST_READ: begin
        if (!wait_ff) begin
          nxt_state = fmad_pkg::ST_IDLE;
        end
      end
      fmad_pkg::ST_WRITE: begin
        if (pulse_over) begin
          nxt_state = fmad_pkg::ST_IDLE;
        end
      end
      fmad_pkg::ST_ERASE: begin
        if (pulse_over || abort_erase) begin
          nxt_state = fmad_pkg::ST_IDLE;
        end
      end
      fmad_pkg::ST_DEV_ERASE: begin
        if (pulse_over && dev_lb_ff) begin
          nxt_state = fmad_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= fmad_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // read wait-state flag
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wait_ff <= 1'b0;
    end else if (state_ff == fmad_pkg::ST_IDLE) begin
      wait_ff <= WAIT_STATE;
    end else if (state_ff == fmad_pkg::ST_READ) begin
      wait_ff <= 1'b0;
    end
  end

  // oscillator tick counter, reloaded for each pulse
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_cnt_ff <= 16'h0000;
    end else if (take_req) begin
      tick_cnt_ff <= (req_kind_in == fmad_pkg::KIND_WRITE) ? WRITE_TICKS : ERASE_TICKS;
    end else if (start_dev || (state_ff == fmad_pkg::ST_DEV_ERASE && pulse_over)) begin
      tick_cnt_ff <= ERASE_TICKS;
    end else if (osc_tick_in && tick_cnt_ff != 16'h0000) begin
      tick_cnt_ff <= tick_cnt_ff - 16'h0001;
    end
  end

  // device erase walk: main pages in order, then the lock page
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dev_page_ff <= 5'h00;
      dev_lb_ff   <= 1'b0;
    end else if (start_dev) begin
      dev_page_ff <= 5'h00;
      dev_lb_ff   <= 1'b0;
    end else if (state_ff == fmad_pkg::ST_DEV_ERASE && pulse_over) begin
      if (dev_page_ff == LAST_PAGE) begin
        dev_lb_ff <= 1'b1; // user data page is skipped
      end else begin
        dev_page_ff <= dev_page_ff + 5'h01;
      end
    end
  end

  // flash array strobes, address and data
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      flash_rd_ff    <= 1'b0;
      flash_prog_ff  <= 1'b0;
      flash_erase_ff <= 1'b0;
      flash_addr_ff  <= 32'h0000_0000;
      flash_wdata_ff <= 32'h0000_0000;
    end else begin
      flash_rd_ff    <= (nxt_state == fmad_pkg::ST_READ);
      flash_prog_ff  <= (nxt_state == fmad_pkg::ST_WRITE);
      flash_erase_ff <= (nxt_state == fmad_pkg::ST_ERASE) ||
                        (nxt_state == fmad_pkg::ST_DEV_ERASE);
      if (take_req) begin
        flash_addr_ff  <= req_addr_in;
        flash_wdata_ff <= req_wdata_in;
      end else if (start_dev) begin
        flash_addr_ff <= fmad_pkg::MAIN_BASE;
      end else if (state_ff == fmad_pkg::ST_DEV_ERASE && pulse_over) begin
        // erase addresses are page aligned: low ten bits stay zero
        flash_addr_ff <= (dev_page_ff == LAST_PAGE) ? fmad_pkg::LB_BASE :
                         {22'h000000, dev_page_ff + 5'h01, 5'h00} << 5;
      end
    end
  end

  // bus answer: one-cycle valid, error for refused or aborted work
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      resp_valid_ff <= 1'b0;
      resp_err_ff   <= 1'b0;
      rdata_ff      <= fmad_pkg::RDATA_RST;
    end else begin
      resp_valid_ff <= 1'b0;
      resp_err_ff   <= 1'b0;
      if (take_req && refuse) begin
        resp_valid_ff <= 1'b1;
        resp_err_ff   <= 1'b1;
      end else if (state_ff == fmad_pkg::ST_READ && !wait_ff) begin
        resp_valid_ff <= 1'b1;
        rdata_ff      <= flash_rdata_in;
      end else if (state_ff == fmad_pkg::ST_WRITE && pulse_over) begin
        resp_valid_ff <= 1'b1;
      end else if (state_ff == fmad_pkg::ST_ERASE && (pulse_over || abort_erase)) begin
        resp_valid_ff <= 1'b1;
        resp_err_ff   <= !pulse_over; // aborted erase reports error
      end
    end
  end

  // completion events, one cycle each
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      write_done_ff <= 1'b0;
      erase_done_ff <= 1'b0;
    end else begin
      write_done_ff <= (state_ff == fmad_pkg::ST_WRITE) && pulse_over;
      erase_done_ff <= pulse_over && ((state_ff == fmad_pkg::ST_ERASE) ||
                       (state_ff == fmad_pkg::ST_DEV_ERASE && dev_lb_ff));
    end
  end

  // outputs
  assign resp_valid_out       = resp_valid_ff;
  assign resp_err_out         = resp_err_ff;
  assign resp_rdata_out       = rdata_ff;
  assign flash_rd_out         = flash_rd_ff;
  assign flash_prog_out       = flash_prog_ff;
  assign flash_erase_out      = flash_erase_ff;
  assign flash_addr_out       = flash_addr_ff;
  assign flash_wdata_out      = flash_wdata_ff;
  assign write_done_out       = write_done_ff;
  assign erase_done_out       = erase_done_ff;
  assign debug_erase_busy_out = (state_ff == fmad_pkg::ST_DEV_ERASE);

endmodule

// file: dv/fmad_checker_properties.sv
// Purpose: port-level checks of the flash map access decoder
// Assumes: one outstanding request, default core clock above 16 MHz
// Notes:   refusals are judged on the cycle right after the take
`timescale 1ns/100ps
module fmad_checker (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        nrst_in,
  // bus
  input wire logic        req_valid_in,
  input wire logic [1:0]  req_kind_in,
  input wire logic [31:0] req_addr_in,
  input wire logic        req_dma_in,
  input wire logic        req_debug_in,
  input wire logic        req_ready_out,
  input wire logic        resp_valid_out,
  input wire logic        resp_err_out,
  // system state and events
  input wire logic [2:0]  energy_mode_in,
  input wire logic [31:0] page_lock_word_in,
  input wire logic        debug_erase_busy_out,
  input wire logic        write_done_out,
  input wire logic        erase_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // a request is taken on this edge
  wire logic tk = req_valid_in && req_ready_out;
  wire logic rf = resp_valid_out && resp_err_out;

  chk_main_gap: assert property (
    tk && req_addr_in >= 32'h0000_8000 && req_addr_in < 32'h0fe0_0000 |=> rf)
    else $error("main gap access not refused");
  chk_lb_erase: assert property (
    tk && req_kind_in == 2'h2 && !req_debug_in && req_addr_in[31:10] == 22'h03f810 |=> rf)
    else $error("software erase of lock page not refused");
  chk_di_ro: assert property (
    tk && req_kind_in != 2'h0 && req_addr_in[31:10] == 22'h03f820 |=> rf)
    else $error("change of info page not refused");
  chk_top_rsvd: assert property (
    tk && req_addr_in >= 32'h0fe1_0000 |=> rf)
    else $error("upper reserved access not refused");
  chk_deep_mode: assert property (
    tk && energy_mode_in > 3'h1 |=> rf)
    else $error("access in deep mode not refused");
  chk_cpu_sleep: assert property (
    tk && req_kind_in == 2'h1 && !req_dma_in && !req_debug_in && energy_mode_in == 3'h1
    |=> rf) else $error("cpu write in sleep not refused");
  chk_read_wait: assert property (
    tk && req_kind_in == 2'h0 && energy_mode_in < 3'h2 && req_addr_in[31:10] == 22'h03f800
    |=> (!resp_valid_out) [*2] ##1 (resp_valid_out && !resp_err_out))
    else $error("read answer not after one wait state");
  chk_lock_bit: assert property (
    tk && req_kind_in != 2'h0 && req_addr_in < 32'h0000_8000
    && !page_lock_word_in[req_addr_in[14:10]] |=> rf)
    else $error("locked page change not refused");
  chk_busy_block: assert property (
    debug_erase_busy_out |-> !req_ready_out)
    else $error("request accepted during device erase");
  chk_done_split: assert property (
    write_done_out |-> !erase_done_out)
    else $error("write and erase done together");
endmodule

bind fmad_flash_map_access_decoder fmad_checker chk_u (.clk_in, .nrst_in, .req_valid_in,
  .req_kind_in, .req_addr_in, .req_dma_in, .req_debug_in, .req_ready_out, .resp_valid_out,
  .resp_err_out, .energy_mode_in, .page_lock_word_in, .debug_erase_busy_out,
  .write_done_out, .erase_done_out);

// file: dv/fmad_bus_master.sv
// Purpose: bus master model standing for the core and dma side
// Assumes: one request at a time, as the decoder allows
// Notes:   released address and data lines show inverted junk
`timescale 1ns/100ps
module fmad_bus_master (
  // clock
  input  wire logic        clk_in,
  // answer from the decoder
  input  wire logic        req_ready_in,
  input  wire logic        resp_valid_in,
  input  wire logic        resp_err_in,
  input  wire logic [31:0] resp_rdata_in,
  // request to the decoder
  output logic             req_valid_out,
  output logic [1:0]       req_kind_out,
  output logic [31:0]      req_addr_out,
  output logic [31:0]      req_wdata_out,
  output logic             req_dma_out,
  output logic             req_debug_out
);
  initial begin
    req_valid_out = 1'b0;
    req_kind_out = 2'h0;
    req_addr_out = 32'h0;
    req_wdata_out = 32'h0;
    req_dma_out = 1'b0;
    req_debug_out = 1'b0;
  end

  // hold the request until the edge that takes it, then wait for the answer
  task automatic access(input logic [1:0] k, input logic [31:0] a, input logic [31:0] wd,
                        input logic d, input logic g, output logic e, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b1;
    req_kind_out = k;
    req_addr_out = a;
    req_wdata_out = wd;
    req_dma_out = d;
    req_debug_out = g;
    @(posedge clk_in);
    while (req_ready_in !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_in);
    end
    #1;
    // released lines must not look like the last request
    req_valid_out = 1'b0;
    req_addr_out = ~a;
    req_wdata_out = ~wd;
    n = 0;
    while (resp_valid_in !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    e = (n < 2000) ? resp_err_in : 1'bx;
    rd = resp_rdata_in;
  endtask
endmodule

// file: dv/fmad_flash_map_access_decoder_bench.sv
// Purpose: self-checking bench of the flash map access decoder
// Assumes: short pulse tick counts, oscillator tick every fourth cycle
// Notes:   flash array answers address xor a fixed mask
`timescale 1ns/100ps
module fmad_flash_map_access_decoder_bench;
  logic        clk_in, nrst_in, osc_tick_in, erase_abort_en_in, irq_pending_in;
  logic        debug_erase_start_in, req_valid_in, req_dma_in, req_debug_in, req_ready_out;
  logic        resp_valid_out, resp_err_out, debug_erase_busy_out, flash_rd_out;
  logic        flash_prog_out, flash_erase_out, write_done_out, erase_done_out, e;
  logic        ud_hit = 1'b0;
  logic [1:0]  req_kind_in;
  logic [2:0]  energy_mode_in;
  logic [31:0] req_addr_in, req_wdata_in, resp_rdata_out, page_lock_word_in, rd;
  logic [31:0] flash_addr_out, flash_wdata_out, prog_wd;
  logic [31:0] cyc = 32'h0, mask = 32'h0;
  wire  [31:0] flash_rdata_in = flash_rd_out ? flash_addr_out ^ 32'ha5a5_0f0f : ~cyc;
  int          seed, miscompares, check_count, wd_cnt, ed_cnt, r, n;
  logic [31:0] bases [8] = '{32'h0, 32'h7c00, 32'h8000, 32'h0fe0_0000, 32'h0fe0_0400,
                             32'h0fe0_4000, 32'h0fe0_8000, 32'h0fe1_0000};
  logic [35:0] cc [12] = '{{4'h4, 32'h0}, {4'h4, 32'h7c00}, {4'h0, 32'h8000},
                           {4'h0, 32'h0fe0_0400}, {4'h8, 32'h0fe0_0000}, {4'h8, 32'h0fe0_4000},
                           {4'h9, 32'h0fe0_4000}, {4'h4, 32'h0fe0_8000}, {4'h0, 32'h0fe0_8004},
                           {4'h0, 32'h0fe1_0000}, {4'hc, 32'h0}, {4'ha, 32'h400}};

  fmad_flash_map_access_decoder #(.WRITE_TICKS(16'h0002), .ERASE_TICKS(16'h0003)) dut_u (
    .clk_in, .nrst_in, .req_valid_in, .req_kind_in, .req_addr_in, .req_wdata_in, .req_dma_in,
    .req_debug_in, .req_ready_out, .resp_valid_out, .resp_err_out, .resp_rdata_out,
    .energy_mode_in, .page_lock_word_in, .erase_abort_en_in, .irq_pending_in, .osc_tick_in,
    .debug_erase_start_in, .debug_erase_busy_out, .flash_rd_out, .flash_prog_out,
    .flash_erase_out, .flash_addr_out, .flash_wdata_out, .flash_rdata_in, .write_done_out,
    .erase_done_out);

  fmad_bus_master bm_u (.clk_in, .req_ready_in(req_ready_out), .resp_valid_in(resp_valid_out),
    .resp_err_in(resp_err_out), .resp_rdata_in(resp_rdata_out), .req_valid_out(req_valid_in),
    .req_kind_out(req_kind_in), .req_addr_out(req_addr_in), .req_wdata_out(req_wdata_in),
    .req_dma_out(req_dma_in), .req_debug_out(req_debug_in));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // oscillator ticks, event counts and device erase coverage
  always @(posedge clk_in) begin
    cyc <= cyc + 32'h1;
    osc_tick_in <= (cyc[1:0] == 2'h3);
    if (write_done_out === 1'b1) wd_cnt++;
    if (erase_done_out === 1'b1) ed_cnt++;
    // last word seen on the array while a program pulse stands
    if (flash_prog_out === 1'b1) prog_wd = flash_wdata_out;
    if (flash_erase_out === 1'b1 && debug_erase_busy_out === 1'b1) begin
      if (flash_addr_out < 32'h8000) mask[flash_addr_out[14:10]] = 1'b1;
      if (flash_addr_out[31:10] == 22'h03f800) ud_hit = 1'b1;
    end
  end

  // refusal expected from map, mode, master and lock word
  function automatic logic exp_err(logic [1:0] k, logic [31:0] a, logic d, logic g);
    logic [21:0] p;
    p = a[31:10];
    if (k == 2'h3 || energy_mode_in > 3'h1) return 1'b1;
    if (k != 2'h0 && !g && !d && energy_mode_in != 3'h0) return 1'b1;
    if (d && k == 2'h2) return 1'b1;
    if (a < 32'h8000) return k != 2'h0 && !page_lock_word_in[a[14:10]];
    if (p == 22'h03f800) return 1'b0;
    if (p == 22'h03f810) return k == 2'h2 && !g;
    if (p == 22'h03f820) return k != 2'h0;
    return 1'b1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic run_one(input logic [1:0] k, input logic [31:0] a, input logic d, input logic g);
    int w0, e0;
    logic [31:0] wd;
    w0 = wd_cnt;
    e0 = ed_cnt;
    wd = $random(seed);
    bm_u.access(k, a, wd, d, g, e, rd);
    // wait three edges so the event counters see the done pulse, then step off the edge
    repeat (3) @(posedge clk_in);
    #1;
    chk("resp_err", exp_err(k, a, d, g), e);
    if (k == 2'h0 && e === 1'b0) chk("rdata", a ^ 32'ha5a5_0f0f, rd);
    chk("write_done", k == 2'h1 && e === 1'b0, wd_cnt != w0);
    if (k == 2'h1 && e === 1'b0) chk("flash_wdata", wd, prog_wd);
    chk("erase_done", k == 2'h2 && e === 1'b0, ed_cnt != e0);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    test_done;
  end

  initial begin
    seed = 68130;
    {nrst_in, erase_abort_en_in, irq_pending_in, debug_erase_start_in} = 4'h0;
    energy_mode_in = 3'h0;
    page_lock_word_in = 32'hffff_fffe;
    repeat (20) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    foreach (cc[i]) run_one(cc[i][35:34], cc[i][31:0], cc[i][33], cc[i][32]);
    $display("test corners done");
    for (int m = 0; m < 3; m++) begin
      energy_mode_in = m[2:0];
      for (int s = 0; s < 3; s++) run_one(2'h1, 32'h0fe0_0010, s == 1, s == 2);
      run_one(2'h0, 32'h0fe0_0020, 1'b1, 1'b0);
    end
    $display("test modes done");
    energy_mode_in = 3'h0;
    erase_abort_en_in = 1'b1;
    irq_pending_in = 1'b1;
    bm_u.access(2'h2, 32'h0fe0_0000, 32'h0, 1'b0, 1'b0, e, rd);
    chk("abort_err", 1'b1, e);
    {erase_abort_en_in, irq_pending_in} = 2'h0;
    $display("test abort done");
    for (int i = 0; i < 150; i++) begin
      energy_mode_in = 3'({$random(seed)} % 3);
      page_lock_word_in = $random(seed);
      irq_pending_in = $random(seed);
      r = {$random(seed)} % 3;
      run_one(2'($random(seed)), bases[{$random(seed)} % 8] + ($random(seed) & 32'h3fc),
              r == 1, r == 2);
    end
    $display("test random done");
    n = ed_cnt;
    @(posedge clk_in);
    #1 debug_erase_start_in = 1'b1;
    @(posedge clk_in);
    #1 debug_erase_start_in = 1'b0;
    for (int i = 0; i < 5000 && debug_erase_busy_out !== 1'b0; i++) @(posedge clk_in);
    repeat (3) @(posedge clk_in);
    chk("main_erased", 32'hffff_ffff, mask);
    chk("ud_kept", 1'b0, ud_hit);
    chk("dev_erase_done", 1'b1, ed_cnt != n);
    $display("test device erase done");
    test_done;
  end
endmodule
